// [rsc_pkg.sv]
// Constants shared by the reset and sleep recovery controller.
`default_nettype none
package rsc_pkg;
    localparam int         SYS_DELAY_IPO  = 66;
    localparam int         XTAL_DELAY_IPO = 5000;
    localparam int         PIN_MIN_LOW    = 3;
    localparam int         PIN_ECHO_CYC   = 5;
    localparam logic [15:0] RESET_VECTOR  = 16'h0002;
    localparam int         AXI_AW         = 8;
    localparam logic [7:0] OFS_CAUSE      = 8'h00;
    localparam logic [7:0] OFS_DEBUG      = 8'h04;
    localparam logic [7:0] OFS_WAKE       = 8'h08;
    localparam int         CAUSE_EXT_BIT  = 0;
    localparam int         CAUSE_WDT_BIT  = 1;
    localparam int         CAUSE_SMR_BIT  = 2;
    localparam int         CAUSE_POR_BIT  = 3;
    localparam int         CAUSE_FLD_LSB  = 4;
    localparam int         DEBUG_RST_BIT  = 0;
    localparam logic [3:0] CAUSE_RST_VAL  = 4'h0;
    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_SLVERR    = 2'h2;
    typedef enum logic [2:0] {ST_RUN, ST_SLEEP, ST_RESET, ST_HOLD, ST_RECOVER} rsc_state_t;
endpackage
`default_nettype wire

// [rsc_pin_filter.sv]
// Synchroniser and low-width filter for the external reset pin.
`timescale 1ns/100ps
`default_nettype none
module rsc_pin_filter #(
    parameter int MIN_LOW = rsc_pkg::PIN_MIN_LOW
) (
    input  wire logic ref_clk,
    input  wire logic arst_n,
    input  wire logic pin_in,
    output var  logic pin_low
);
    import rsc_pkg::*;
    localparam int CW = $clog2(MIN_LOW + 1);
    localparam logic [CW-1:0] SAT = CW'(MIN_LOW - 1);

    logic          sync1;
    logic          sync2;
    logic [CW-1:0] low_cnt;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1 <= 1'b1;
            sync2 <= 1'b1;
        end else begin
            sync1 <= pin_in;
            sync2 <= sync1;
        end
    end

    // Counts consecutive low samples, so a pulse shorter than the minimum never passes.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            low_cnt <= '0;
            pin_low <= 1'b0;
        end else begin
            if (sync2) begin
                low_cnt <= '0;
            end else if (low_cnt != SAT) begin
                low_cnt <= low_cnt + 1'b1;
            end
            pin_low <= !sync2 && (low_cnt == SAT);
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    a_pin_min_width: assert property ($rose(pin_low) |-> $past(!sync2, 2) && $past(!sync2, 3))
        else $error("reset pin accepted after too short a low pulse");
endmodule // rsc_pin_filter
`default_nettype wire

// [rsc_reset_ctrl.sv]
// Reset sequencer and sleep recovery controller with an AXI4-Lite register port.
// Function
// - Ignore reset pin pulses under three clocks.
// - Debugger reset request self-clears during reset.
// - Power-on delay longer with crystal option.
// - Power-on exit sets power-on cause flag.
// - Brown-out holds reset, then full sequence.
// - Option bit keeps brown-out alive in sleep.
// - Watchdog resets or interrupts by option.
// - Watchdog reset sets watchdog cause flag.
// - Pin low four clocks always resets; the code ignores the pin while the device drives it and for 5 cycles after.
// - Held pin extends reset until release.
// - Pin reset sets external cause flag.
// - Drive pin low during internal reset delay.
// - Recovery holds CPU 66 or 5000 cycles.
// - Recovery restores watchdog, oscillator; selects internal oscillator.
// - Every exit fetches vector at 0002H.
// - Recovery sets the sleep-recovery cause flag.
// - Sleep watchdog time-out wakes, maybe interrupts.
// - Enabled wake pin change triggers recovery.
// - Pin or debug pin in sleep resets.
// - Sleep entered only by sleep instruction.
// - Reading cause register clears upper flags.
//
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module rsc_reset_ctrl #(
    parameter int SYS_DELAY  = rsc_pkg::SYS_DELAY_IPO,
    parameter int XTAL_DELAY = rsc_pkg::XTAL_DELAY_IPO,
    parameter int WAKE_W     = 8
) (
    input  wire logic                      ref_clk,
    input  wire logic                      arst_n,
    input  wire logic                      por_ok,
    input  wire logic                      brownout_detect,
    input  wire logic                      brownout_in_sleep_option,
    input  wire logic                      watchdog_action_option,
    input  wire logic                      xtal_option,
    input  wire logic                      ipo_tick,
    input  wire logic                      watchdog_timeout,
    input  wire logic                      sleep_instr,
    input  wire logic                      debug_pin_in,
    input  wire logic                      reset_pin_in,
    input  wire logic                      port_drive_en,
    input  wire logic [WAKE_W-1:0]         wake_pins,
    output var  logic                      reset_pin_out,
    output var  logic                      reset_pin_oe,
    output var  logic                      cpu_reset,
    output var  logic                      deep_sleep,
    output var  logic                      watchdog_irq,
    output var  logic                      restore_ctrl,
    output var  logic                      ipo_force,
    output var  logic                      vector_fetch,
    output var  logic [15:0]               vector_addr,
    input  wire logic [rsc_pkg::AXI_AW-1:0] s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output var  logic                      s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output var  logic                      s_axi_wready,
    output var  logic [1:0]                s_axi_bresp,
    output var  logic                      s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [rsc_pkg::AXI_AW-1:0] s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output var  logic                      s_axi_arready,
    output var  logic [31:0]               s_axi_rdata,
    output var  logic [1:0]                s_axi_rresp,
    output var  logic                      s_axi_rvalid,
    input  wire logic                      s_axi_rready
);
    import rsc_pkg::*;
    localparam int CNT_W = $clog2(XTAL_DELAY + 1);
    localparam logic [CNT_W-1:0] SYS_LIM  = CNT_W'(SYS_DELAY);
    localparam logic [CNT_W-1:0] XTAL_LIM = CNT_W'(XTAL_DELAY);
    localparam logic [2:0]       ECHO_LIM = 3'(PIN_ECHO_CYC);

    rsc_state_t        state;
    rsc_state_t        next_state;
    logic [CNT_W-1:0]  cnt;
    logic [CNT_W-1:0]  limit;
    logic              done;
    logic              pin_low;
    logic              ext_low;
    logic [2:0]        echo;
    logic              brown;
    logic              dbg_rst;
    logic [WAKE_W-1:0] wake_en;
    logic [WAKE_W-1:0] wake_prev;
    logic              wake_change;
    logic              wdt_reset;
    logic              run_req;
    logic              sleep_req;
    logic              entering;
    logic              leaving;
    logic              pend_por;
    logic              pend_wdt;
    logic              pend_ext;
    logic              pend_irq;
    logic [3:0]        cause;
    logic [3:0]        cause_set;
    logic              wr_fire;
    logic              rd_fire;
    logic              cause_rd;

    rsc_pin_filter #(
        .MIN_LOW (PIN_MIN_LOW)
    ) u_pin_filter (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .pin_in  (reset_pin_in),
        .pin_low (pin_low)
    );

    // Our own drive on the pin echoes back through the filter; it is masked for a few cycles.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            echo <= ECHO_LIM;
        end else if (reset_pin_oe) begin
            echo <= ECHO_LIM;
        end else if (echo != 3'h0) begin
            echo <= echo - 3'h1;
        end
    end

    always_comb begin
        ext_low     = pin_low && (echo == 3'h0);
        brown       = !por_ok || (brownout_detect && (state != ST_SLEEP || brownout_in_sleep_option));
        wdt_reset   = watchdog_timeout && watchdog_action_option;
        run_req     = ext_low || dbg_rst || wdt_reset;
        sleep_req   = ext_low || !debug_pin_in;
        wake_change = |((wake_pins ^ wake_prev) & wake_en);
        limit       = xtal_option ? XTAL_LIM : SYS_LIM;
        done        = (cnt >= limit);
    end

    always_comb begin
        next_state = state;
        case (state)
            ST_RUN: begin
                if (run_req) begin
                    next_state = ST_RESET;
                end else if (sleep_instr) begin
                    next_state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (sleep_req) begin
                    next_state = ST_RESET;
                end else if (watchdog_timeout || wake_change) begin
                    next_state = ST_RECOVER;
                end
            end
            ST_RESET: begin
                if (done && por_ok) begin
                    next_state = ext_low ? ST_HOLD : ST_RUN;
                end
            end
            ST_HOLD: begin
                if (!ext_low) begin
                    next_state = ST_RUN;
                end
            end
            ST_RECOVER: begin
                if (sleep_req) begin
                    next_state = ST_RESET;
                end else if (done) begin
                    next_state = ST_RUN;
                end
            end
            default: next_state = ST_RUN;
        endcase
        if (brown) begin
            next_state = ST_RESET;
        end
    end

    always_comb begin
        entering = (next_state == ST_RESET || next_state == ST_RECOVER) && (next_state != state);
        leaving  = (next_state == ST_RUN) && (state != ST_RUN) && (state != ST_SLEEP);
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state      <= ST_RESET;
            cpu_reset  <= 1'b1;
            deep_sleep <= 1'b0;
        end else begin
            state      <= next_state;
            cpu_reset  <= (next_state != ST_RUN) && (next_state != ST_SLEEP);
            deep_sleep <= (next_state == ST_SLEEP);
        end
    end

    // Delay counter in internal oscillator cycles; low supply or brown-out restarts it.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= '0;
        end else if (entering || brown) begin
            cnt <= '0;
        end else if (ipo_tick && !done) begin
            cnt <= cnt + 1'b1;
        end
    end

    // Pending causes, turned into status flags when the sequence ends.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pend_por <= 1'b1;
            pend_wdt <= 1'b0;
            pend_ext <= 1'b0;
            pend_irq <= 1'b0;
        end else if (leaving) begin
            pend_por <= 1'b0;
            pend_wdt <= 1'b0;
            pend_ext <= 1'b0;
            pend_irq <= 1'b0;
        end else begin
            if (brown || (state == ST_RUN && dbg_rst)) begin
                pend_por <= 1'b1;
            end
            if ((state == ST_RUN && wdt_reset) || (state == ST_SLEEP && watchdog_timeout)) begin
                pend_wdt <= 1'b1;
            end
            if (ext_low && state != ST_HOLD && !pend_wdt && !pend_por) begin
                pend_ext <= 1'b1;
            end
            if (state == ST_SLEEP && watchdog_timeout && !watchdog_action_option) begin
                pend_irq <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            reset_pin_out <= 1'b0;
            reset_pin_oe  <= 1'b1;
        end else begin
            reset_pin_out <= 1'b0;
            reset_pin_oe  <= port_drive_en
                || (next_state == ST_RESET && !(ext_low || pend_ext));
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            watchdog_irq <= 1'b0;
            restore_ctrl <= 1'b0;
            ipo_force    <= 1'b0;
            vector_fetch <= 1'b0;
            vector_addr  <= RESET_VECTOR;
        end else begin
            watchdog_irq <= (state == ST_RUN && next_state == ST_RUN && watchdog_timeout
                && !watchdog_action_option) || (leaving && pend_irq);
            restore_ctrl <= leaving && (state == ST_RECOVER);
            ipo_force    <= leaving;
            vector_fetch <= leaving;
            vector_addr  <= RESET_VECTOR;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wake_prev <= '0;
        end else begin
            wake_prev <= wake_pins;
        end
    end

    always_comb begin
        cause_set                = '0;
        cause_set[CAUSE_POR_BIT] = leaving && pend_por;
        cause_set[CAUSE_WDT_BIT] = leaving && pend_wdt;
        cause_set[CAUSE_EXT_BIT] = leaving && pend_ext;
        cause_set[CAUSE_SMR_BIT] = leaving && (state == ST_RECOVER);
        cause_rd                 = rd_fire && (s_axi_araddr == OFS_CAUSE);
    end

    // A flag raised in the same cycle as a clearing read stays set.
    for (genvar i = 0; i < 4; i++) begin : g_cause
        always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
                cause[i] <= CAUSE_RST_VAL[i];
            end else if (cause_set[i]) begin
                cause[i] <= 1'b1;
            end else if (cause_rd) begin
                cause[i] <= 1'b0;
            end
        end
    end

    always_comb begin
        wr_fire = s_axi_awready;
        rd_fire = s_axi_arready;
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (s_axi_awaddr == OFS_CAUSE || s_axi_awaddr == OFS_DEBUG
                    || s_axi_awaddr == OFS_WAKE) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            dbg_rst <= 1'b0;
            wake_en <= '0;
        end else begin
            if (state == ST_RESET) begin
                dbg_rst <= 1'b0;
            end else if (wr_fire && s_axi_awaddr == OFS_DEBUG && s_axi_wstrb[0]) begin
                dbg_rst <= s_axi_wdata[DEBUG_RST_BIT];
            end
            if (wr_fire && s_axi_awaddr == OFS_WAKE && s_axi_wstrb[0]) begin
                wake_en <= s_axi_wdata[WAKE_W-1:0];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= RESP_OKAY;
                s_axi_rdata  <= '0;
                case (s_axi_araddr)
                    OFS_CAUSE: s_axi_rdata[CAUSE_FLD_LSB +: 4] <= cause;
                    OFS_DEBUG: s_axi_rdata[DEBUG_RST_BIT] <= dbg_rst;
                    OFS_WAKE:  s_axi_rdata[WAKE_W-1:0] <= wake_en;
                    default:   s_axi_rresp <= RESP_SLVERR;
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    a_sleep_entry: assert property ($rose(deep_sleep) |-> $past(sleep_instr))
        else $error("deep sleep entered without a sleep instruction");
    a_dbg_clear: assert property (state == ST_RESET |=> !dbg_rst)
        else $error("debugger reset request not cleared during reset");
    a_por_flag: assert property ($fell(cpu_reset) && $past(pend_por) |-> cause[CAUSE_POR_BIT])
        else $error("power-on flag missing after power-on reset");
    a_wdt_flag: assert property ($fell(cpu_reset) && $past(pend_wdt) |-> cause[CAUSE_WDT_BIT])
        else $error("watchdog flag missing after watchdog reset");
    a_ext_flag: assert property ($fell(cpu_reset) && $past(pend_ext) |-> cause[CAUSE_EXT_BIT])
        else $error("external flag missing after pin reset");
    a_smr_flag: assert property ($fell(cpu_reset) && $past(state) == ST_RECOVER
        |-> cause[CAUSE_SMR_BIT] && restore_ctrl && ipo_force)
        else $error("sleep recovery flag or restore missing");
    a_brown_hold: assert property (!por_ok |=> cpu_reset && cnt == '0)
        else $error("reset not held while supply is low");
    a_hold_pin: assert property (state == ST_HOLD && ext_low |=> cpu_reset)
        else $error("reset released while pin still low");
    a_pin_drive: assert property (state == ST_RESET && !pend_ext && !ext_low |-> reset_pin_oe)
        else $error("reset pin not driven during internal reset");
    a_delay_len: assert property ($fell(cpu_reset) && $past(state) != ST_HOLD
        |-> $past(cnt) >= $past(limit))
        else $error("reset released before delay elapsed");
    a_wdt_irq: assert property (state == ST_RUN && next_state == ST_RUN && watchdog_timeout
        && !watchdog_action_option |=> watchdog_irq)
        else $error("watchdog interrupt not raised");
    a_vector: assert property ($fell(cpu_reset) |-> vector_fetch && vector_addr == RESET_VECTOR)
        else $error("vector fetch missing on reset exit");
    a_read_clear: assert property (cause_rd && cause_set == '0 |=> cause == '0)
        else $error("cause flags not cleared by read");

    c_recovery: cover property ($fell(cpu_reset) && cause[CAUSE_SMR_BIT]);
    c_hold: cover property (state == ST_HOLD ##1 state == ST_RUN);
    c_wdt_irq: cover property ($rose(watchdog_irq));
    c_debug_rst: cover property (state == ST_RUN && dbg_rst ##1 state == ST_RESET);
endmodule // rsc_reset_ctrl
`default_nettype wire

// [rsc_reset_net.sv]
// Board reset net model: pull-up, open-drain device driver and an external pusher.
`timescale 1ns/100ps
`default_nettype none
module rsc_reset_net (
    input  wire logic dev_out,
    input  wire logic dev_oe,
    input  wire logic ext_low,
    output var  logic pin_level
);
    // The pull-up wins only while nobody pulls the net low.
    always_comb pin_level = !((dev_oe && !dev_out) || ext_low);
endmodule // rsc_reset_net
`default_nettype wire

// [reset_and_sleep_recovery_control_tb.sv]
// Self-checking bench for the reset and sleep recovery controller.
`timescale 1ns/100ps
`default_nettype none
module reset_and_sleep_recovery_control_tb;
    import rsc_pkg::*;
    localparam int SD = 6;
    localparam int XD = 20;
    logic ref_clk, arst_n, por_ok, bo, bo_opt, wd_opt, xtal, ipo_tick, wd_to, slp, dbg_n, ext_low;
    logic pin_in, pin_out, pin_oe, cpu_reset, deep_sleep, wd_irq, restore, ipo_force, vfetch;
    logic awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic pde;
    logic [3:0] hs;
    logic [7:0] wake, awaddr, araddr;
    logic [15:0] vaddr;
    logic [31:0] wdata, rdata, rd, v;
    int seed = 32'hc488e65f;
    int err_total = 0;
    int compares = 0;
    int n, ticks, exp_cause;
    assign hs = {rvalid, arready, bvalid, awready};

    rsc_reset_ctrl #(.SYS_DELAY(SD), .XTAL_DELAY(XD), .WAKE_W(8)) dut_u (
        .ref_clk(ref_clk), .arst_n(arst_n), .por_ok(por_ok), .brownout_detect(bo),
        .brownout_in_sleep_option(bo_opt), .watchdog_action_option(wd_opt), .xtal_option(xtal),
        .ipo_tick(ipo_tick), .watchdog_timeout(wd_to), .sleep_instr(slp), .debug_pin_in(dbg_n),
        .reset_pin_in(pin_in), .port_drive_en(pde), .wake_pins(wake), .reset_pin_out(pin_out),
        .reset_pin_oe(pin_oe), .cpu_reset(cpu_reset), .deep_sleep(deep_sleep),
        .watchdog_irq(wd_irq), .restore_ctrl(restore), .ipo_force(ipo_force),
        .vector_fetch(vfetch), .vector_addr(vaddr), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1));
    rsc_reset_net net_u (.dev_out(pin_out), .dev_oe(pin_oe), .ext_low(ext_low), .pin_level(pin_in));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = !ref_clk;
    end
    always @(posedge ref_clk) ipo_tick <= 1'($random(seed));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        if (err_total == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic wt(input int w);
        n = 0;
        do begin
            @(posedge ref_clk);
            if (++n > 400) begin
                chk(32'h0, 32'h1);
                complete_run();
            end
        end while (hs[w] !== 1'b1);
    endtask
    task automatic pls(input int w);
        case (w)
            0: bo <= 1'b1;
            1: wd_to <= 1'b1;
            default: slp <= 1'b1;
        endcase
        @(posedge ref_clk);
        {bo, wd_to, slp} <= 3'h0;
    endtask
    // Counts oscillator ticks seen while the reset output has not yet reached the wanted level.
    task automatic wait_rst(input logic lvl);
        ticks = 0;
        for (n = 0; cpu_reset !== lvl; n++) begin
            if (n > 400) begin
                chk(32'h0, 32'h1);
                complete_run();
            end
            ticks += int'(ipo_tick === 1'b1);
            @(posedge ref_clk);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        wt(0);
        chk(32'(wready), 32'h1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        wt(1);
    endtask
    task automatic axr(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        wt(2);
        arvalid <= 1'b0;
        wt(3);
        rd = rdata;
    endtask
    task automatic rdc;
        axr(OFS_CAUSE);
        chk(rd, 32'(exp_cause));
        exp_cause = 0;
    endtask
    task automatic leave(input int d);
        wait_rst(1'b0);
        chk(32'(ticks >= d - 1 && ticks <= d + 3), 32'h1);
        chk({15'h0, vfetch, vaddr}, {15'h0, 1'b1, 16'h0002});
        chk(32'(ipo_force), 32'h1);
    endtask

    initial begin
        {arst_n, bo, bo_opt, xtal, wd_to, slp, ext_low, awvalid, wvalid, arvalid, pde} = '0;
        {por_ok, wd_opt, dbg_n} = 3'h7;
        {wake, awaddr, araddr, wdata} = '0;
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        exp_cause = 32'h80;
        leave(SD);
        rdc();
        rdc();
        xtal <= 1'b1;
        por_ok <= 1'b0;
        pls(0);
        wait_rst(1'b1);
        chk(32'(pin_oe), 32'h1);
        repeat (4) @(posedge ref_clk);
        chk(32'(cpu_reset), 32'h1);
        por_ok <= 1'b1;
        leave(XD);
        xtal <= 1'b0;
        exp_cause = 32'h80;
        rdc();
        ext_low <= 1'b1;
        repeat (2) @(posedge ref_clk);
        ext_low <= 1'b0;
        repeat (10) @(posedge ref_clk);
        chk(32'(cpu_reset), 32'h0);
        ext_low <= 1'b1;
        repeat (4) @(posedge ref_clk);
        ext_low <= 1'b0;
        wait_rst(1'b1);
        leave(SD);
        exp_cause = 32'h10;
        rdc();
        ext_low <= 1'b1;
        wait_rst(1'b1);
        repeat (SD * 4 + 20) @(posedge ref_clk);
        chk(32'(cpu_reset), 32'h1);
        ext_low <= 1'b0;
        wait_rst(1'b0);
        chk(32'(n <= 5), 32'h1);
        axw(OFS_CAUSE, 32'h0);
        chk(32'(bresp), 32'h0);
        pde <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk({30'h0, pin_oe, pin_out}, 32'h2);
        pde <= 1'b0;
        pls(1);
        wait_rst(1'b1);
        leave(SD);
        exp_cause = 32'h30;
        rdc();
        wd_opt <= 1'b0;
        pls(1);
        @(posedge ref_clk);
        chk({31'h0, wd_irq}, 32'h1);
        chk(32'(cpu_reset), 32'h0);
        axw(OFS_DEBUG, 32'h1);
        wait_rst(1'b1);
        leave(SD);
        axr(OFS_DEBUG);
        chk(rd, 32'h0);
        exp_cause = 32'h80;
        rdc();
        v = $random(seed);
        axw(OFS_WAKE, v);
        axr(OFS_WAKE);
        chk(rd, v & 32'hff);
        axw(OFS_WAKE, 32'h1);
        for (int k = 0; k < 3; k++) begin
            pls(2);
            @(posedge ref_clk);
            chk(32'(deep_sleep), 32'h1);
            if (k == 0) {bo, wake[0]} <= {1'b1, !wake[0]};
            if (k == 1) wd_to <= 1'b1;
            if (k == 2) dbg_n <= 1'b0;
            @(posedge ref_clk);
            {bo, wd_to} <= 2'h0;
            wait_rst(1'b1);
            dbg_n <= 1'b1;
            if (k < 2) begin
                wait_rst(1'b0);
                chk({30'h0, restore, wd_irq}, {30'h0, 1'b1, k == 1});
            end else begin
                leave(SD);
            end
            exp_cause = (k == 0) ? 32'h40 : (k == 1) ? 32'h60 : 32'h0;
            rdc();
        end
        axr(8'h0c);
        chk(32'(rresp), 32'(RESP_SLVERR));
        complete_run();
    end
endmodule // reset_and_sleep_recovery_control_tb
`default_nettype wire
